// ===== core/power_mode_pkg.sv
// Constants, types and register map of the power-mode and wake controller
package power_mode_pkg;

  // APB register byte offsets
  localparam logic [7:0] CLOCK_MODE_OFF  = 8'h00;
  localparam logic [7:0] CTRL_OFF        = 8'h04;
  localparam logic [7:0] STATUS_OFF      = 8'h08;
  localparam logic [7:0] WAKE_MASK_OFF   = 8'h0C;

  // Field positions in clock_mode_register
  localparam int CM_HS_BIT    = 0;
  localparam int CM_IDLE_BIT  = 1;
  localparam int CM_FRDY_BIT  = 2;
  localparam int CM_DIV_LSB   = 5;
  // Field positions in control and status registers
  localparam int CTRL_KEEP_BIT = 7;
  localparam int ST_TO_BIT     = 0;
  localparam int ST_PDF_BIT    = 1;
  localparam int ST_MODE_LSB   = 4;

  // Values after reset
  localparam logic [2:0] DIVIDER_RESET     = 3'h6;
  localparam logic       HS_SELECT_RESET   = 1'b0;
  localparam logic       IDLE_ENABLE_RESET = 1'b1;
  localparam logic       IDLE_KEEP_RESET   = 1'b0;

  // Divider codes at or below this pick the sub clock while high-speed select is zero
  localparam logic [2:0] DIV_SUB_MAX = 3'h1;

  // Cycles from power-on or wake until the fast oscillator reads ready
  localparam logic [4:0] FAST_READY_CYCLES = 5'h10;

  // Power modes, one-hot
  typedef enum logic [3:0] {
    MODE_RUN       = 4'h1,
    MODE_SLEEP     = 4'h2,
    MODE_IDLE_STOP = 4'h4,
    MODE_IDLE_RUN  = 4'h8
  } power_mode_e;

  // Clock gating towards the clock tree
  typedef struct packed {
    logic       sys_clk_en;
    logic       time_base_clk_en;
    logic       sub_clk_en;
    logic       osc_en;
    logic       high_speed_path;
    logic [2:0] divider;
  } clock_ctrl_s;

  // One-cycle actions towards the core after a wake
  typedef struct packed {
    logic resume_next;
    logic irq_service;
    logic pc_sp_reset;
  } wake_action_s;

endpackage : power_mode_pkg

// ===== core/power_mode_wake_control.sv
// Power-mode, halt entry and wake-up controller with APB register access
//
// How it works
// - High-speed select one, or divider code 010..111, selects the fast oscillator path.
// - Halt with idle enable zero enters deep sleep; nothing else does.
// - Deep sleep stops system and time base clocks; core held at halt.
// - Halt with idle enable one and clock keep zero enters idle-stop.
// - Idle-stop stops system clock, keeps time base and sub clocks running.
// - Halt with idle enable and clock keep both one enters idle-run.
// - Idle-run keeps system, time base and sub clocks; core held at halt.
// - Halted modes retain memory, registers and port states.
// - Halt clears the watchdog counter, which then counts on from zero.
// - Halt sets the power-down flag and clears the timeout flag.
// - Halted modes wake on port A falling edge, interrupt or watchdog overflow.
// - Watchdog overflow wake starts a watchdog reset and sets the timeout flag.
// - Power-down flag clears on power-up and clear-watchdog; halt sets it.
// - Watchdog wake resets only program counter and stack pointer.
// - Each port A pin has a wake mask bit; only enabled pins wake.
// - Port A wake resumes at the instruction after halt.
// - Disabled interrupt or full stack wake resumes after halt; request stays pending.
// - Enabled interrupt with stack room wakes into normal interrupt response.
// - Interrupt already requested at halt entry cannot wake that period.
// - Fast ready reads low in sleep and idle-stop, rises 16 cycles after wake.
// - Oscillator stops in idle-stop, keeps running in idle-run.
// - High-speed select zero with divider 000 or 001 selects the sub clock.
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

module power_mode_wake_control
  import power_mode_pkg::*;
#(
  parameter int PORT_A_W = 8,
  parameter int IRQ_W    = 8
) (
  // APB slave
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output var  logic [31:0]         prdata,
  output var  logic                pready,
  output var  logic                pslverr,
  // Processor core
  input  wire logic                halt_exec,
  input  wire logic                clr_wdt_exec,
  input  wire logic                stack_full,
  output var  logic                cpu_hold,
  output var  logic                state_retain,
  output var  wake_action_s        wake_action,
  // Interrupt controller
  input  wire logic [IRQ_W-1:0]    irq_req,
  input  wire logic [IRQ_W-1:0]    irq_enable,
  // Watchdog counter
  input  wire logic                wdt_overflow,
  output var  logic                wdt_clear,
  // Port A pins, asynchronous
  input  wire logic [PORT_A_W-1:0] port_a,
  // Clock tree
  output var  clock_ctrl_s         clock_ctrl
);

  function automatic logic is_halted(input power_mode_e m);
    is_halted = (m != MODE_RUN);
  endfunction : is_halted

  function automatic logic fast_path(input logic hs, input logic [2:0] div);
    fast_path = hs || (div > DIV_SUB_MAX);
  endfunction : fast_path

  // Software-visible control
  logic                high_speed_select;
  logic [2:0]          divider_select;
  logic                idle_enable;
  logic                idle_clock_keep;
  logic [PORT_A_W-1:0] port_a_wake_mask;
  logic                powerdown_flag;
  logic                watchdog_timeout_flag;
  logic                fast_osc_ready;
  logic [4:0]          ready_count;

  power_mode_e         mode;
  power_mode_e         next_mode;
  logic [IRQ_W-1:0]    irq_blocked;

  // APB decode
  logic setup_phase;
  logic write_take;
  logic addr_hit;
  assign setup_phase = psel && !penable;
  assign write_take  = psel && penable && pready && pwrite;
  assign addr_hit    = (paddr == CLOCK_MODE_OFF) || (paddr == CTRL_OFF) ||
                       (paddr == STATUS_OFF) || (paddr == WAKE_MASK_OFF);

  // Port A synchroniser and falling-edge detect
  logic [PORT_A_W-1:0] pa_meta;
  logic [PORT_A_W-1:0] pa_sync;
  logic [PORT_A_W-1:0] pa_last;
  logic                pa_wake;

  // One synchroniser and edge detector per pin; history starts high like an idle pin
  for (genvar p = 0; p < PORT_A_W; p++) begin : g_pa
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pa_meta[p] <= 1'b1;
        pa_sync[p] <= 1'b1;
      end else begin
        pa_meta[p] <= port_a[p];
        pa_sync[p] <= pa_meta[p];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pa_last[p] <= 1'b1;
      end else begin
        pa_last[p] <= pa_sync[p];
      end
    end
  end

  assign pa_wake = |(pa_last & ~pa_sync & port_a_wake_mask);

  // Wake decode
  logic             halt_take;
  logic [IRQ_W-1:0] irq_wake_set;
  logic             irq_wake;
  logic             wdt_wake;
  logic             any_wake;
  assign halt_take    = halt_exec && (mode == MODE_RUN);
  assign irq_wake_set = irq_req & ~irq_blocked;
  assign irq_wake     = |irq_wake_set;
  assign wdt_wake     = is_halted(mode) && wdt_overflow;
  assign any_wake     = is_halted(mode) && (wdt_overflow || irq_wake || pa_wake);

  // Mode selection; the idle bits are read only at the halt itself
  always_comb begin
    next_mode = mode;
    if (halt_take) begin
      if (!idle_enable) begin
        next_mode = MODE_SLEEP;
      end else if (!idle_clock_keep) begin
        next_mode = MODE_IDLE_STOP;
      end else begin
        next_mode = MODE_IDLE_RUN;
      end
    end else if (any_wake) begin
      next_mode = MODE_RUN;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= MODE_RUN;
    end else begin
      case (mode)
        MODE_RUN, MODE_SLEEP, MODE_IDLE_STOP, MODE_IDLE_RUN: mode <= next_mode;
        default: mode <= MODE_RUN;
      endcase
    end
  end

  // Requests already raised at entry never count as wake sources
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_blocked <= '0;
    end else if (halt_take) begin
      irq_blocked <= irq_req;
    end else if (!is_halted(mode)) begin
      irq_blocked <= '0;
    end
  end

  // Core hold follows the next mode, so the core stops in step with the clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_hold <= 1'b0;
    end else begin
      cpu_hold <= is_halted(next_mode);
    end
  end

  // Retention request for memory, registers and port latches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_retain <= 1'b0;
    end else begin
      state_retain <= is_halted(next_mode);
    end
  end

  // Watchdog clear, one pulse per halt taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_clear <= 1'b0;
    end else begin
      wdt_clear <= halt_take;
    end
  end

  // Wake actions; watchdog wins over interrupt, interrupt over port A
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_action <= '0;
    end else begin
      wake_action <= '0;
      if (wdt_wake) begin
        wake_action.pc_sp_reset <= 1'b1;
      end else if (is_halted(mode) && irq_wake) begin
        if ((|(irq_wake_set & irq_enable)) && !stack_full) begin
          wake_action.irq_service <= 1'b1;
        end else begin
          wake_action.resume_next <= 1'b1;
        end
      end else if (is_halted(mode) && pa_wake) begin
        wake_action.resume_next <= 1'b1;
      end
    end
  end

  // Power-down flag; halt set wins over a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      powerdown_flag <= 1'b0;
    end else if (halt_take) begin
      powerdown_flag <= 1'b1;
    end else if (clr_wdt_exec) begin
      powerdown_flag <= 1'b0;
    end
  end

  // Timeout flag; an overflow set wins over the halt clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_timeout_flag <= 1'b0;
    end else if (wdt_overflow) begin
      watchdog_timeout_flag <= 1'b1;
    end else if (halt_take) begin
      watchdog_timeout_flag <= 1'b0;
    end
  end

  // Fast oscillator settle count, restarted by sleep and idle-stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_count <= '0;
    end else if (next_mode == MODE_SLEEP || next_mode == MODE_IDLE_STOP) begin
      ready_count <= '0;
    end else if (ready_count != FAST_READY_CYCLES) begin
      ready_count <= ready_count + 5'h01;
    end
  end

  // Ready drops at the stopping edge and rises as the count reaches its end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_osc_ready <= 1'b0;
    end else if (next_mode == MODE_SLEEP || next_mode == MODE_IDLE_STOP) begin
      fast_osc_ready <= 1'b0;
    end else if (ready_count != FAST_READY_CYCLES) begin
      fast_osc_ready <= (ready_count == FAST_READY_CYCLES - 5'h01);
    end
  end

  // Clock tree gating, registered so the tree sees no glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_ctrl.sys_clk_en       <= 1'b1;
      clock_ctrl.time_base_clk_en <= 1'b1;
      clock_ctrl.sub_clk_en       <= 1'b1;
      clock_ctrl.osc_en           <= 1'b0;
      clock_ctrl.high_speed_path  <= 1'b0;
      clock_ctrl.divider          <= DIVIDER_RESET;
    end else begin
      clock_ctrl.sys_clk_en       <= (next_mode == MODE_RUN) ||
                                     (next_mode == MODE_IDLE_RUN);
      clock_ctrl.time_base_clk_en <= (next_mode != MODE_SLEEP);
      clock_ctrl.sub_clk_en       <= 1'b1;
      clock_ctrl.osc_en           <= (next_mode == MODE_IDLE_RUN) ||
                                     ((next_mode == MODE_RUN) &&
                                      fast_path(high_speed_select, divider_select));
      clock_ctrl.high_speed_path  <= fast_path(high_speed_select, divider_select);
      clock_ctrl.divider          <= divider_select;
    end
  end

  // Clock mode fields, committed at the APB access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_speed_select <= HS_SELECT_RESET;
      divider_select    <= DIVIDER_RESET;
      idle_enable       <= IDLE_ENABLE_RESET;
    end else if (write_take && paddr == CLOCK_MODE_OFF) begin
      high_speed_select <= pwdata[CM_HS_BIT];
      divider_select    <= pwdata[CM_DIV_LSB +: 3];
      idle_enable       <= pwdata[CM_IDLE_BIT];
    end
  end

  // Idle clock keep only matters at the halt itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_clock_keep <= IDLE_KEEP_RESET;
    end else if (write_take && paddr == CTRL_OFF) begin
      idle_clock_keep <= pwdata[CTRL_KEEP_BIT];
    end
  end

  // Per-pin wake enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_a_wake_mask <= '0;
    end else if (write_take && paddr == WAKE_MASK_OFF) begin
      port_a_wake_mask <= pwdata[PORT_A_W-1:0];
    end
  end

  // One wait-free access cycle after every setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_phase;
    end
  end

  // Error only for holes in the map; status writes are dropped without one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup_phase && !addr_hit;
    end
  end

  // Read data loaded in the setup cycle, zero at every other time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else begin
      prdata <= '0;
      if (setup_phase && !pwrite) begin
        case (paddr)
          CLOCK_MODE_OFF: begin
            prdata[CM_DIV_LSB +: 3] <= divider_select;
            prdata[CM_FRDY_BIT]     <= fast_osc_ready;
            prdata[CM_IDLE_BIT]     <= idle_enable;
            prdata[CM_HS_BIT]       <= high_speed_select;
          end
          CTRL_OFF: begin
            prdata[CTRL_KEEP_BIT] <= idle_clock_keep;
          end
          STATUS_OFF: begin
            prdata[ST_TO_BIT]       <= watchdog_timeout_flag;
            prdata[ST_PDF_BIT]      <= powerdown_flag;
            prdata[ST_MODE_LSB +: 4] <= mode;
          end
          WAKE_MASK_OFF: begin
            prdata[PORT_A_W-1:0] <= port_a_wake_mask;
          end
          default: begin
          end
        endcase
      end
    end
  end

endmodule : power_mode_wake_control

`default_nettype wire

// ===== bench/power_mode_wake_control_assertions.sv
// Checker for the power-mode and wake controller ports
`timescale 1ns/1ps
`default_nettype none
module pmw_checker
  import power_mode_pkg::*;
(
  // Clock, reset and core side
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         halt_exec,
  input wire logic         wdt_overflow,
  input wire logic         cpu_hold,
  input wire logic         state_retain,
  input wire logic         wdt_clear,
  input wire wake_action_s wake_action,
  // Clock tree
  input wire clock_ctrl_s  clock_ctrl
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Halt only counts from running code
  sequence s_halt;
    halt_exec && !cpu_hold;
  endsequence
  sequence s_wdt_wake;
    cpu_hold && wdt_overflow;
  endsequence
  AST_HALT_HOLD: assert property (s_halt |=> cpu_hold && state_retain)
    else $error("core not held after halt");
  AST_HALT_WDT_CLR: assert property (s_halt |=> wdt_clear ##1 !wdt_clear)
    else $error("watchdog clear pulse wrong after halt");
  AST_SLEEP_CLK: assert property (cpu_hold && !clock_ctrl.time_base_clk_en |->
    !clock_ctrl.sys_clk_en && !clock_ctrl.osc_en) else $error("sleep clocks wrong");
  AST_STOP_CLK: assert property (cpu_hold && !clock_ctrl.sys_clk_en |->
    clock_ctrl.sub_clk_en && !clock_ctrl.osc_en) else $error("stop clocks wrong");
  AST_IDLE_RUN: assert property (cpu_hold && clock_ctrl.sys_clk_en |->
    clock_ctrl.osc_en && clock_ctrl.time_base_clk_en) else $error("idle-run clocks wrong");
  AST_WDT_WAKE: assert property (s_wdt_wake |=> wake_action.pc_sp_reset && !cpu_hold)
    else $error("watchdog wake missing");
  AST_RESUME: assert property ($rose(wake_action.resume_next) |-> $fell(cpu_hold))
    else $error("resume without release");
  AST_RUN_PATH: assert property (!cpu_hold |->
    clock_ctrl.osc_en == clock_ctrl.high_speed_path) else $error("run path mismatch");
  AST_QUIET_RUN: assert property (!cpu_hold |=> wake_action == 3'h0)
    else $error("wake action while running");
endmodule : pmw_checker
bind power_mode_wake_control pmw_checker u_chk (
  .pclk(pclk), .presetn(presetn), .halt_exec(halt_exec), .wdt_overflow(wdt_overflow),
  .cpu_hold(cpu_hold), .state_retain(state_retain), .wdt_clear(wdt_clear),
  .wake_action(wake_action), .clock_ctrl(clock_ctrl)
);
`default_nettype wire

// ===== bench/core_model.sv
// Behavioural processor core issuing halt and following wake actions
`timescale 1ns/1ps
`default_nettype none
module core_model
  import power_mode_pkg::*;
(
  // Clock, reset and bench request
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         halt_req,
  // Controller side
  input  wire logic         cpu_hold,
  input  wire wake_action_s wake_action,
  output var  logic         halt_exec,
  output var  logic [7:0]   pc,
  output var  wake_action_s last_act
);
  // A held core cannot execute halt, so no request while halted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_exec <= 1'b0;
    end else begin
      halt_exec <= halt_req && !cpu_hold && !halt_exec;
    end
  end
  // Program counter follows the wake action
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc       <= 8'h10;
      last_act <= 3'h0;
    end else if (wake_action != 3'h0) begin
      last_act <= wake_action;
      if (wake_action.pc_sp_reset) pc <= 8'h00;
      else if (wake_action.irq_service) pc <= 8'h04;
      else pc <= pc + 8'h01;
    end
  end
endmodule : core_model
`default_nettype wire

// ===== bench/testbench.sv
// Testbench for the power-mode and wake controller
`timescale 1ns/1ps
`default_nettype none
module testbench import power_mode_pkg::*;;
  logic         pclk, presetn, psel, penable, pwrite, halt_req, halt_exec;
  logic         clr_wdt_exec, stack_full, cpu_hold, state_retain, wdt_overflow;
  logic         wdt_clear, pready, pslverr, serr;
  logic [7:0]   paddr, irq_req, irq_enable, port_a, pc;
  logic [31:0]  pwdata, prdata, rdata;
  wake_action_s wake_action, last_act;
  clock_ctrl_s  clock_ctrl;
  int           errors = 0;
  int           checked = 0;
  power_mode_wake_control uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .halt_exec(halt_exec), .clr_wdt_exec(clr_wdt_exec), .stack_full(stack_full),
    .cpu_hold(cpu_hold), .state_retain(state_retain), .wake_action(wake_action),
    .irq_req(irq_req), .irq_enable(irq_enable), .wdt_overflow(wdt_overflow),
    .wdt_clear(wdt_clear), .port_a(port_a), .clock_ctrl(clock_ctrl)
  );
  core_model core (
    .pclk(pclk), .presetn(presetn), .halt_req(halt_req), .cpu_hold(cpu_hold),
    .wake_action(wake_action), .halt_exec(halt_exec), .pc(pc), .last_act(last_act)
  );
  always #20 pclk = ~pclk;
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Extra edge after release keeps back-to-back calls from double-driving psel
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    serr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, e, rdata);
  endtask : rd
  task automatic enter(input logic ie, input logic kp, input logic [3:0] m, input logic [3:0] c);
    apb(1'b1, CLOCK_MODE_OFF, {24'h0, 3'h6, 3'h0, ie, 1'b0});
    apb(1'b1, CTRL_OFF, {24'h0, kp, 7'h0});
    halt_req <= 1'b1;
    @(posedge pclk);
    halt_req <= 1'b0;
    cyc(3);
    chk("hold", 32'h1, {31'h0, cpu_hold});
    chk("clocks", {28'h0, c}, {28'h0, clock_ctrl[7:4]});
    rd(STATUS_OFF, {24'h0, m, 4'h2}, "status");
    rd(CLOCK_MODE_OFF, {24'h0, 3'h6, 2'h0, c[0], ie, 1'b0}, "ready");
  endtask : enter
  task automatic wake;
    repeat (20) begin
      @(posedge pclk);
      if (cpu_hold === 1'b0) break;
    end
    @(posedge pclk);
  endtask : wake
  task automatic stop_test;
    $display("Checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  // Whole run needs well under a thousand cycles
  initial begin
    cyc(5000);
    errors++;
    stop_test();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, halt_req, clr_wdt_exec, stack_full, wdt_overflow} = 7'h0;
    {paddr, irq_req, irq_enable, pwdata} = 56'h0;
    port_a = 8'hFF;
    cyc(20);
    presetn <= 1'b1;
    cyc(20);
    rd(CLOCK_MODE_OFF, 32'hC6, "clock_mode");
    rd(CTRL_OFF, 32'h0, "ctrl");
    apb(1'b1, STATUS_OFF, 32'hFF);
    rd(STATUS_OFF, 32'h10, "status");
    rd(8'h10, 32'h0, "unmapped");
    chk("slverr", 32'h1, {31'h0, serr});
    $display("registers done");
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, CLOCK_MODE_OFF, {24'h0, i[2:0], 4'h1, (i == 8)});
      cyc(2);
      chk("fast_path", {31'h0, i > 1}, {31'h0, clock_ctrl.high_speed_path});
    end
    $display("clock select done");
    apb(1'b1, WAKE_MASK_OFF, 32'h2);
    enter(1'b0, 1'b0, 4'h2, 4'h2);
    port_a <= 8'hFE;
    cyc(8);
    chk("masked pin", 32'h1, {31'h0, cpu_hold});
    port_a <= 8'hFC;
    wake();
    chk("wake", 32'h4, {29'h0, last_act});
    chk("pc", 32'h11, {24'h0, pc});
    rd(CLOCK_MODE_OFF, 32'hC0, "ready low");
    cyc(16);
    rd(CLOCK_MODE_OFF, 32'hC4, "ready high");
    port_a <= 8'hFF;
    $display("sleep done");
    irq_enable <= 8'hFF;
    irq_req <= 8'h01;
    enter(1'b1, 1'b0, 4'h4, 4'h6);
    cyc(8);
    chk("stale irq", 32'h1, {31'h0, cpu_hold});
    stack_full <= 1'b1;
    irq_req <= 8'h03;
    wake();
    chk("wake", 32'h4, {29'h0, last_act});
    irq_req <= 8'h00;
    stack_full <= 1'b0;
    $display("idle-stop done");
    enter(1'b1, 1'b1, 4'h8, 4'hF);
    wdt_overflow <= 1'b1;
    @(posedge pclk);
    wdt_overflow <= 1'b0;
    wake();
    chk("wake", 32'h1, {29'h0, last_act});
    rd(STATUS_OFF, 32'h13, "status");
    clr_wdt_exec <= 1'b1;
    @(posedge pclk);
    clr_wdt_exec <= 1'b0;
    rd(STATUS_OFF, 32'h11, "status");
    chk("pdf", 32'h0, {31'h0, rdata[1]});
    $display("idle-run done");
    irq_enable <= 8'h04;
    enter(1'b0, 1'b0, 4'h2, 4'h2);
    irq_req <= 8'h04;
    wake();
    chk("wake", 32'h2, {29'h0, last_act});
    chk("pc", 32'h4, {24'h0, pc});
    $display("interrupt wake done");
    presetn <= 1'b0;
    cyc(2);
    presetn <= 1'b1;
    cyc(2);
    rd(STATUS_OFF, 32'h10, "status after reset");
    rd(CLOCK_MODE_OFF, 32'hC2, "clock_mode after reset");
    $display("reset done");
    stop_test();
  end
endmodule : testbench
`default_nettype wire
